// *** src/rotate_right_via_carry_op_consts.vh ***
// Purpose: constants for the rotate-right-through-carry execution block
// Assumes: 16-bit instruction word, 8-bit data, 4-bit bank select
// Notes:   definitions only
`ifndef RRCI_CONSTS_VH
`define RRCI_CONSTS_VH

`define RRCI_OPC_W        6
`define RRCI_OPC_VALUE    6'h0C
`define RRCI_OPC_HI       15
`define RRCI_OPC_LO       10
`define RRCI_DEST_BIT     9
`define RRCI_ACC_BIT      8
`define RRCI_F_HI         7
`define RRCI_F_LO         0
`define RRCI_DATA_W       8
`define RRCI_DATA_MSB     7
`define RRCI_DATA_LSB     0
`define RRCI_LIT_MAX      8'h5F
`define RRCI_ACC_SPLIT    8'h60
`define RRCI_ACC_HI_BANK  4'hF
`define RRCI_ACC_LO_BANK  4'h0
`define RRCI_BSR_W        4
`define RRCI_ADDR_W       12
`define RRCI_BYTE_ZERO    8'h00
`define RRCI_ADDR_ZERO    12'h000
`define RRCI_ST_IDLE      2'h0
`define RRCI_ST_READ      2'h1
`define RRCI_ST_WRITE     2'h2

`endif

// *** src/rrci_addr_gen.v ***
// Purpose: operand address generation for byte-oriented access
// Assumes: fixed access bank split at 60h; indexed mode adds the field to an index base
// Notes:   purely combinational
`timescale 1ns/1ps
`include "rotate_right_via_carry_op_consts.vh"

module rrci_addr_gen (
  input  wire [7:0]                f_field_in,
  input  wire                      bank_access_in,
  input  wire                      ext_set_en_in,
  input  wire [`RRCI_BSR_W-1:0]    bank_select_register_in,
  input  wire [`RRCI_ADDR_W-1:0]   index_base_in,
  output reg  [`RRCI_ADDR_W-1:0]   addr_out,
  output reg                       indexed_out
);

  always @* begin
    indexed_out = 1'b0;
    if (bank_access_in) begin
      addr_out = {bank_select_register_in, f_field_in};
    end else if (ext_set_en_in && (f_field_in <= `RRCI_LIT_MAX)) begin
      indexed_out = 1'b1;
      addr_out    = index_base_in + {4'h0, f_field_in};
    end else if (f_field_in < `RRCI_ACC_SPLIT) begin
      addr_out = {`RRCI_ACC_LO_BANK, f_field_in};
    end else begin
      addr_out = {`RRCI_ACC_HI_BANK, f_field_in};
    end
  end

endmodule

// *** src/rrci_core.v ***
// Purpose: execute the rotate-right-through-carry byte instruction
// Assumes: synchronous data memory port with one-cycle read latency
// Notes:   decode, read, process and write mirror the four-phase instruction timing
`timescale 1ns/1ps
`include "rotate_right_via_carry_op_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module rrci_core (
  input  wire                      clk_sys_in,
  input  wire                      rst_n_in,
  input  wire                      instr_valid_in,
  input  wire [15:0]               instr_word_in,
  input  wire                      ext_set_en_in,
  input  wire [`RRCI_BSR_W-1:0]    bank_select_register_in,
  input  wire [`RRCI_ADDR_W-1:0]   index_base_in,
  input  wire                      carry_in,
  input  wire [7:0]                mem_rdata_in,
  output wire                      instr_ready_out,
  output wire                      instr_match_out,
  output wire                      mem_rd_out,
  output wire                      mem_wr_out,
  output wire [`RRCI_ADDR_W-1:0]   mem_addr_out,
  output wire [7:0]                mem_wdata_out,
  output wire                      acc_we_out,
  output wire [7:0]                acc_wdata_out,
  output wire                      flags_we_out,
  output wire                      carry_out,
  output wire                      negative_out,
  output wire                      zero_out,
  output wire                      indexed_out,
  output wire                      done_out
);

  localparam [1:0] ST_IDLE  = `RRCI_ST_IDLE;
  localparam [1:0] ST_READ  = `RRCI_ST_READ;
  localparam [1:0] ST_WRITE = `RRCI_ST_WRITE;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer state and latched instruction fields
  reg  [1:0]                 state_r;
  reg  [1:0]                 state_nxt;
  reg                        dest_r;
  reg                        dest_nxt;
  reg                        carry_old_r;
  reg                        carry_old_nxt;

  // registered outputs
  reg                        mem_rd_r;
  reg                        mem_rd_nxt;
  reg                        mem_wr_r;
  reg                        mem_wr_nxt;
  reg  [`RRCI_ADDR_W-1:0]    mem_addr_r;
  reg  [`RRCI_ADDR_W-1:0]    mem_addr_nxt;
  reg  [`RRCI_DATA_W-1:0]    mem_wdata_r;
  reg  [`RRCI_DATA_W-1:0]    mem_wdata_nxt;
  reg                        acc_we_r;
  reg                        acc_we_nxt;
  reg  [`RRCI_DATA_W-1:0]    acc_wdata_r;
  reg  [`RRCI_DATA_W-1:0]    acc_wdata_nxt;
  reg                        flags_we_r;
  reg                        flags_we_nxt;
  reg                        carry_r;
  reg                        carry_nxt;
  reg                        negative_r;
  reg                        negative_nxt;
  reg                        zero_r;
  reg                        zero_nxt;
  reg                        indexed_r;
  reg                        indexed_nxt;
  reg                        done_r;
  reg                        done_nxt;

  wire [`RRCI_DATA_W-1:0]    result_c;
  wire [`RRCI_ADDR_W-1:0]    addr_c;
  wire                       indexed_c;
  wire                       match_c;
  wire                       idle_c;
  wire                       take_c;

  ////////////////////////////////////////////////////////////////////////////////
  // opcode prefix match
  assign match_c = (instr_word_in[`RRCI_OPC_HI:`RRCI_OPC_LO] == `RRCI_OPC_VALUE);
  assign idle_c  = (state_r == ST_IDLE);
  // words with another opcode, or offered while busy, are dropped without trace
  assign take_c  = instr_valid_in && match_c && idle_c;

  assign instr_match_out = match_c;
  assign instr_ready_out = idle_c;

  rrci_addr_gen u_addr (
    .f_field_in              (instr_word_in[`RRCI_F_HI:`RRCI_F_LO]),
    .bank_access_in          (instr_word_in[`RRCI_ACC_BIT]),
    .ext_set_en_in           (ext_set_en_in),
    .bank_select_register_in (bank_select_register_in),
    .index_base_in           (index_base_in),
    .addr_out                (addr_c),
    .indexed_out             (indexed_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // shift down one
  genvar gi;
  generate
    for (gi = 0; gi < `RRCI_DATA_MSB; gi = gi + 1) begin : g_rot
      assign result_c[gi] = mem_rdata_in[gi + 1];
    end
  endgenerate

  assign result_c[`RRCI_DATA_MSB] = carry_old_r;

  ////////////////////////////////////////////////////////////////////////////////
  // pulses drop back to zero by default, held values keep their last state
  always @* begin
    state_nxt     = state_r;
    dest_nxt      = dest_r;
    carry_old_nxt = carry_old_r;
    mem_rd_nxt    = 1'b0;
    mem_wr_nxt    = 1'b0;
    mem_addr_nxt  = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    acc_we_nxt    = 1'b0;
    acc_wdata_nxt = acc_wdata_r;
    flags_we_nxt  = 1'b0;
    carry_nxt     = carry_r;
    negative_nxt  = negative_r;
    zero_nxt      = zero_r;
    indexed_nxt   = indexed_r;
    done_nxt      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take_c) begin
          // address and carry are latched here so later changes cannot corrupt them
          state_nxt     = ST_READ;
          dest_nxt      = instr_word_in[`RRCI_DEST_BIT];
          carry_old_nxt = carry_in;
          mem_addr_nxt  = addr_c;
          indexed_nxt   = indexed_c;
          mem_rd_nxt    = 1'b1;
        end
      end
      ST_READ: begin
        // memory answers one cycle after the read pulse
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        state_nxt = ST_IDLE;
        if (dest_r) begin
          mem_wr_nxt    = 1'b1;
          mem_wdata_nxt = result_c;
        end else begin
          acc_we_nxt    = 1'b1;
          acc_wdata_nxt = result_c;
        end
        flags_we_nxt = 1'b1;
        carry_nxt    = mem_rdata_in[`RRCI_DATA_LSB];
        negative_nxt = result_c[`RRCI_DATA_MSB];
        zero_nxt     = (result_c == `RRCI_BYTE_ZERO);
        done_nxt     = 1'b1;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r     <= ST_IDLE;
      dest_r      <= 1'b0;
      carry_old_r <= 1'b0;
      mem_rd_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_addr_r  <= `RRCI_ADDR_ZERO;
      mem_wdata_r <= `RRCI_BYTE_ZERO;
      acc_we_r    <= 1'b0;
      acc_wdata_r <= `RRCI_BYTE_ZERO;
      flags_we_r  <= 1'b0;
      carry_r     <= 1'b0;
      negative_r  <= 1'b0;
      zero_r      <= 1'b0;
      indexed_r   <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      dest_r      <= dest_nxt;
      carry_old_r <= carry_old_nxt;
      mem_rd_r    <= mem_rd_nxt;
      mem_wr_r    <= mem_wr_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      acc_we_r    <= acc_we_nxt;
      acc_wdata_r <= acc_wdata_nxt;
      flags_we_r  <= flags_we_nxt;
      carry_r     <= carry_nxt;
      negative_r  <= negative_nxt;
      zero_r      <= zero_nxt;
      indexed_r   <= indexed_nxt;
      done_r      <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // every data output leaves straight from a flip-flop
  assign mem_rd_out    = mem_rd_r;
  assign mem_wr_out    = mem_wr_r;
  assign mem_addr_out  = mem_addr_r;
  assign mem_wdata_out = mem_wdata_r;
  assign acc_we_out    = acc_we_r;
  assign acc_wdata_out = acc_wdata_r;
  assign flags_we_out  = flags_we_r;
  assign carry_out     = carry_r;
  assign negative_out  = negative_r;
  assign zero_out      = zero_r;
  assign indexed_out   = indexed_r;
  assign done_out      = done_r;

endmodule

// *** testbench/rrci_core_assertions.sv ***
// Purpose: port-level timing and value checks for rrci_core
// Assumes: one instruction in flight at a time
// Notes:   attached by bind below
`timescale 1ns/1ps
module rrci_core_chk (
  input wire        clk_sys_in,
  input wire        rst_n_in,
  input wire        instr_valid_in,
  input wire        instr_ready_out,
  input wire        instr_match_out,
  input wire        ext_set_en_in,
  input wire        carry_in,
  input wire        mem_rd_out,
  input wire        mem_wr_out,
  input wire        acc_we_out,
  input wire        flags_we_out,
  input wire        carry_out,
  input wire        negative_out,
  input wire        zero_out,
  input wire        indexed_out,
  input wire        done_out,
  input wire [15:0] instr_word_in,
  input wire [3:0]  bank_select_register_in,
  input wire [11:0] mem_addr_out,
  input wire [7:0]  mem_rdata_in,
  input wire [7:0]  mem_wdata_out,
  input wire [7:0]  acc_wdata_out
);
  wire take = instr_valid_in && instr_ready_out && instr_match_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////
  a_read_to_done: assert property (mem_rd_out |-> !instr_ready_out ##2 done_out)
    else $error("done late");
  // carry was taken three edges before the done pulse, the byte one edge before
  a_rotate_value: assert property (done_out |-> carry_out == $past(mem_rdata_in[0])
    && (!mem_wr_out || mem_wdata_out == {$past(carry_in, 3), $past(mem_rdata_in[7:1])})
    && (!acc_we_out || acc_wdata_out == {$past(carry_in, 3), $past(mem_rdata_in[7:1])}))
    else $error("bad rotate");
  a_one_dest: assert property (
    done_out |-> flags_we_out && (mem_wr_out ^ acc_we_out)) else $error("bad dest");
  a_flag_value: assert property (acc_we_out |-> zero_out == (acc_wdata_out == 8'h00)
    && negative_out == acc_wdata_out[7]) else $error("bad flags");
  a_bank_addr: assert property (take && instr_word_in[8] |=> mem_addr_out ==
    {$past(bank_select_register_in), $past(instr_word_in[7:0])}) else $error("bad bank");
  a_access_addr: assert property (take && !instr_word_in[8] && !ext_set_en_in |=>
    mem_addr_out == {$past(instr_word_in[7:0]) < 8'h60 ? 4'h0 : 4'hF, $past(instr_word_in[7:0])})
    else $error("bad access");
  // indexed_out is judged in cycle 3, before any overlapped request can move it
  a_indexed_flag: assert property (take && !instr_word_in[8] && ext_set_en_in
    && instr_word_in[7:0] <= 8'h5F |-> ##3 indexed_out) else $error("no indexed");
  a_opcode_match: assert property (instr_match_out == (instr_word_in[15:10] == 6'h0C))
    else $error("bad match");
endmodule
bind rrci_core rrci_core_chk u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
  .instr_ready_out(instr_ready_out), .instr_match_out(instr_match_out),
  .ext_set_en_in(ext_set_en_in), .carry_in(carry_in), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .acc_we_out(acc_we_out), .flags_we_out(flags_we_out),
  .carry_out(carry_out), .negative_out(negative_out), .zero_out(zero_out),
  .indexed_out(indexed_out), .done_out(done_out), .instr_word_in(instr_word_in),
  .bank_select_register_in(bank_select_register_in), .mem_addr_out(mem_addr_out),
  .mem_rdata_in(mem_rdata_in), .mem_wdata_out(mem_wdata_out), .acc_wdata_out(acc_wdata_out)
);

// *** testbench/tb_rrci_core.sv ***
// Purpose: directed scenarios for rrci_core
// Assumes: memory answers in cycle 2 and holds through cycle 3
// Notes:   no random stimulus
`timescale 1ns/1ps
module tb_rrci_core;
  logic        clk_sys_in = 0, rst_n_in = 0, instr_valid_in = 0, ext_set_en_in = 0, carry_in = 0;
  logic [15:0] instr_word_in = 16'h0000;
  logic [3:0]  bank_select_register_in = 4'h5;
  logic [11:0] index_base_in = 12'h100;
  logic [7:0]  mem_rdata_in = 8'h00;
  wire         instr_ready_out, instr_match_out, mem_rd_out, mem_wr_out, acc_we_out, done_out;
  wire         flags_we_out, carry_out, negative_out, zero_out, indexed_out;
  wire [11:0]  mem_addr_out;
  wire [7:0]   mem_wdata_out, acc_wdata_out;
  int          mismatches = 0, num_checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  rrci_core dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in), .ext_set_en_in(ext_set_en_in), .carry_in(carry_in),
    .bank_select_register_in(bank_select_register_in), .index_base_in(index_base_in),
    .mem_rdata_in(mem_rdata_in), .instr_ready_out(instr_ready_out),
    .instr_match_out(instr_match_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .acc_we_out(acc_we_out),
    .acc_wdata_out(acc_wdata_out), .flags_we_out(flags_we_out), .carry_out(carry_out),
    .negative_out(negative_out), .zero_out(zero_out), .indexed_out(indexed_out),
    .done_out(done_out)
  );
  ////////////////////////
  task chk(input logic [11:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task await(input bit sel);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys_in);
      if ((sel ? done_out : mem_rd_out) === 1'b1) return;
    end
    mismatches++;
    end_of_test();
  endtask
  task op(input logic [15:0] w, input logic x, c, input logic [7:0] d,
          input logic [11:0] ea, input logic ei);
    logic [7:0] r;
    r = {c, d[7:1]};
    @(posedge clk_sys_in);
    instr_valid_in <= 1;
    instr_word_in <= w;
    ext_set_en_in <= x;
    carry_in <= c;
    @(posedge clk_sys_in);
    instr_valid_in <= 0;
    await(0);
    chk(mem_addr_out, ea);
    @(posedge clk_sys_in);
    mem_rdata_in <= d;
    await(1);
    chk(w[9] ? mem_wdata_out : acc_wdata_out, r);
    chk({mem_wr_out, acc_we_out}, {w[9], !w[9]});
    chk({carry_out, negative_out, zero_out}, {d[0], c, r == 8'h00});
    chk(indexed_out, ei);
    // a released read bus shows the inverse, so stale data cannot pass
    @(posedge clk_sys_in);
    mem_rdata_in <= ~d;
  endtask
  task s_bank;
    op(16'h330A, 1, 1, 8'hE6, 12'h50A, 0);
  endtask
  task s_access;
    op(16'h305F, 0, 0, 8'h01, 12'h05F, 0);
    op(16'h3260, 0, 0, 8'h81, 12'hF60, 0);
  endtask
  task s_indexed;
    op(16'h305F, 1, 1, 8'h80, 12'h15F, 1);
    op(16'h3060, 1, 0, 8'h7F, 12'hF60, 0);
  endtask
  task s_foreign;
    @(posedge clk_sys_in);
    instr_valid_in <= 1;
    instr_word_in <= 16'h3460;
    @(posedge clk_sys_in);
    instr_valid_in <= 0;
    repeat (4) begin
      @(negedge clk_sys_in);
      chk({instr_match_out, mem_rd_out}, 2'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1;
    s_bank();
    s_access();
    s_indexed();
    s_foreign();
    end_of_test();
  end
endmodule
